// ---- src/lcdd_pkg.sv ----
// package: constants and types for the lcd display memory segment driver
package lcdd_pkg;

    // data memory map
    localparam logic [7:0] BANK_SELECT_POINTER_ADDR = 8'h04;
    localparam logic [7:0] BANK_SELECT_POINTER_RST = 8'h00;
    localparam logic [7:0] DISP_BANK = 8'h01;
    localparam logic [7:0] DISP_FIRST_ADDR = 8'h40;
    localparam logic [7:0] DISP_LAST_ADDR = 8'h6E;
    localparam int DISP_WORDS = 47;
    localparam int SEG_LINES = 47;
    localparam int COM_LINES = 4;
    localparam int LOGIC_SEGS = 24;
    localparam int GRP_A_LAST = 7;
    localparam int GRP_B_LAST = 15;

    // duty option encoding
    localparam logic [1:0] DUTY_HALF = 2'h0;
    localparam logic [1:0] DUTY_THIRD = 2'h1;
    localparam logic [1:0] DUTY_QUARTER = 2'h2;

    // scan timing: one common phase lasts this long
    localparam int CLK_HZ = 50000000;
    localparam int PHASE_US = 2000;
    localparam int PHASE_CYCLES = (CLK_HZ / 1000000) * PHASE_US;
    localparam logic [16:0] PHASE_LAST = 17'(PHASE_CYCLES - 1);

    // processor data memory access
    typedef struct packed {
        logic wr;
        logic rd;
        logic indirect;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lcdd_mem_req_t;

    // lcd options
    typedef struct packed {
        logic [1:0] duty;
        logic grp_a_logic;
        logic grp_b_logic;
        logic [7:0] bit_logic;
    } lcdd_opt_t;

endpackage : lcdd_pkg

// ---- src/lcdd_scan.sv ----
// phase divider and common-line sequencer for the segment driver
`timescale 1ns/10ps
module lcdd_scan (
    input wire logic clk,
    input wire logic rst,
    input wire logic hold,
    input wire logic [1:0] duty,
    output logic [1:0] phase,
    output logic invert
);
    logic [16:0] cnt_q, cnt_d;
    logic [1:0] phase_q, phase_d;
    logic inv_q, inv_d;
    logic [1:0] last_phase;

    assign phase = phase_q;
    assign invert = inv_q;

    always_comb begin
        case (duty)
            lcdd_pkg::DUTY_HALF: last_phase = 2'h1;
            lcdd_pkg::DUTY_THIRD: last_phase = 2'h2;
            default: last_phase = 2'h3;
        endcase
        cnt_d = cnt_q;
        phase_d = phase_q;
        inv_d = inv_q;
        if (hold) begin
            cnt_d = 17'h00000;
            phase_d = 2'h0;
            inv_d = 1'b0;
        end else if (cnt_q == lcdd_pkg::PHASE_LAST) begin
            cnt_d = 17'h00000;
            // wrapping at duty-1 keeps unused commons out of the scan
            if (phase_q >= last_phase) begin
                phase_d = 2'h0;
                // alternate polarity per frame so the glass sees no dc
                inv_d = ~inv_q;
            end else begin
                phase_d = phase_q + 2'h1;
            end
        end else begin
            cnt_d = cnt_q + 17'h00001;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 17'h00000;
            phase_q <= 2'h0;
            inv_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            phase_q <= phase_d;
            inv_q <= inv_d;
        end
    end

endmodule : lcdd_scan

// ---- src/lcdd_top.sv ----
// lcd display memory, bank window and segment/common drive
`timescale 1ns/10ps
module lcdd_top (
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // processor data memory port
    input wire lcdd_pkg::lcdd_mem_req_t MEM_REQ,
    output logic [7:0] MEM_RDATA,
    output logic MEM_HIT,
    // options and power state
    input wire lcdd_pkg::lcdd_opt_t OPTS,
    input wire logic HALT,
    // glass drive: level and an active flag (inactive means the mid, non-lighting level)
    output logic [3:0] COM_LEVEL,
    output logic [3:0] COM_ACTIVE,
    output logic [46:0] SEG_LEVEL
);
    logic [7:0] bank_q, bank_d;
    logic [7:0] disp_mem [lcdd_pkg::DISP_WORDS];
    logic [7:0] rdata_q, rdata_d;
    logic hit_q, hit_d;
    logic in_window, disp_sel, disp_wr, bank_wr;
    logic [5:0] word_idx;
    logic halt_s1_q, halt_s2_q;
    logic [1:0] phase;
    logic invert;
    logic hold;
    logic [3:0] com_level_q, com_level_d;
    logic [3:0] com_active_q, com_active_d;
    logic [46:0] seg_q, seg_d;
    logic [23:0] seg_logic;

    // ------------------------------------------------------------
    // processor side: bank pointer and display window
    // ------------------------------------------------------------
    assign in_window = MEM_REQ.addr >= lcdd_pkg::DISP_FIRST_ADDR && MEM_REQ.addr <= lcdd_pkg::DISP_LAST_ADDR;
    assign disp_sel = in_window && bank_q == lcdd_pkg::DISP_BANK && MEM_REQ.indirect;
    assign disp_wr = MEM_REQ.wr && disp_sel;
    assign bank_wr = MEM_REQ.wr && MEM_REQ.addr == lcdd_pkg::BANK_SELECT_POINTER_ADDR;
    assign word_idx = 6'(MEM_REQ.addr - lcdd_pkg::DISP_FIRST_ADDR);

    always_comb begin
        bank_d = bank_q;
        rdata_d = rdata_q;
        hit_d = 1'b0;
        if (bank_wr) begin
            bank_d = MEM_REQ.wdata;
        end
        if (MEM_REQ.rd && disp_sel) begin
            rdata_d = disp_mem[word_idx];
            hit_d = 1'b1;
        end else if (MEM_REQ.rd && MEM_REQ.addr == lcdd_pkg::BANK_SELECT_POINTER_ADDR) begin
            rdata_d = bank_q;
            hit_d = 1'b1;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            bank_q <= lcdd_pkg::BANK_SELECT_POINTER_RST;
            rdata_q <= 8'h00;
            hit_q <= 1'b0;
        end else begin
            bank_q <= bank_d;
            rdata_q <= rdata_d;
            hit_q <= hit_d;
        end
    end

    // display image cleared by reset so the glass comes up dark and never scans unknown bits
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < lcdd_pkg::DISP_WORDS; i++) begin
                disp_mem[i] <= 8'h00;
            end
        end else if (disp_wr) begin
            disp_mem[word_idx] <= MEM_REQ.wdata;
        end
    end

    assign MEM_RDATA = rdata_q;
    assign MEM_HIT = hit_q;

    // ------------------------------------------------------------
    // halt synchroniser and common scan
    // ------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            halt_s1_q <= 1'b0;
            halt_s2_q <= 1'b0;
        end else begin
            halt_s1_q <= HALT;
            halt_s2_q <= halt_s1_q;
        end
    end

    assign hold = halt_s2_q;

    lcdd_scan u_scan (
        .clk(CLK),
        .rst(RST),
        .hold(hold),
        .duty(OPTS.duty),
        .phase(phase),
        .invert(invert)
    );

    // ------------------------------------------------------------
    // segment and common drive
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < lcdd_pkg::LOGIC_SEGS; g++) begin : g_logic
            if (g <= lcdd_pkg::GRP_A_LAST) begin : g_a
                assign seg_logic[g] = OPTS.grp_a_logic;
            end else if (g <= lcdd_pkg::GRP_B_LAST) begin : g_b
                assign seg_logic[g] = OPTS.grp_b_logic;
            end else begin : g_c
                assign seg_logic[g] = OPTS.bit_logic[g - lcdd_pkg::GRP_B_LAST - 1];
            end
        end
    endgenerate

    always_comb begin
        com_level_d = 4'h0;
        com_active_d = 4'h0;
        seg_d = 47'h0;
        for (int n = 0; n < lcdd_pkg::SEG_LINES; n++) begin
            // a lit pixel sits opposite the active common; a dark one matches it
            if (n < lcdd_pkg::LOGIC_SEGS && seg_logic[n]) begin
                seg_d[n] = disp_mem[n][0];
            end else if (hold) begin
                seg_d[n] = 1'b0;
            end else if (n == lcdd_pkg::SEG_LINES - 1 && OPTS.duty == lcdd_pkg::DUTY_QUARTER) begin
                seg_d[n] = 1'b0;
            end else begin
                seg_d[n] = disp_mem[n][phase] ^ invert;
            end
        end
        if (!hold) begin
            com_active_d[phase] = 1'b1;
            // common sits at the frame polarity, so a stored 1 (seg = 1 ^ invert) differs from it
            com_level_d[phase] = invert;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            com_level_q <= 4'h0;
            com_active_q <= 4'h0;
            seg_q <= 47'h0;
        end else begin
            com_level_q <= com_level_d;
            com_active_q <= com_active_d;
            seg_q <= seg_d;
        end
    end

    assign COM_LEVEL = com_level_q;
    assign COM_ACTIVE = com_active_q;
    assign SEG_LEVEL = seg_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic pix8_ref;
    logic seg0_ref;

    assign pix8_ref = disp_mem[8][phase] ^ invert;
    assign seg0_ref = disp_mem[0][0];

    chk_direct_no_write: assert property (@(posedge CLK) disable iff (RST)
        MEM_REQ.wr && !MEM_REQ.indirect && in_window |-> !disp_wr)
        else $error("direct write reached display memory");
    chk_bank_gate: assert property (@(posedge CLK) disable iff (RST)
        disp_wr |-> bank_q == 8'h01)
        else $error("display write outside bank one");
    chk_half_no_third_common_line: assert property (@(posedge CLK) disable iff (RST)
        OPTS.duty == 2'h0 |=> !COM_ACTIVE[2] && !COM_ACTIVE[3])
        else $error("third common scanned at half duty");
    chk_third_no_com3: assert property (@(posedge CLK) disable iff (RST)
        OPTS.duty == 2'h1 |=> !COM_ACTIVE[3])
        else $error("fourth common scanned at third duty");
    chk_halt_dark: assert property (@(posedge CLK) disable iff (RST)
        hold |=> COM_ACTIVE == 4'h0)
        else $error("commons active while halted");
    chk_one_common: assert property (@(posedge CLK) disable iff (RST)
        !$past(hold) && !hold |=> $onehot(COM_ACTIVE))
        else $error("scan not exactly one common");
    chk_logic_seg: assert property (@(posedge CLK) disable iff (RST)
        OPTS.grp_a_logic && $stable(OPTS.grp_a_logic) |=> SEG_LEVEL[0] == $past(seg0_ref))
        else $error("logic segment does not follow bit 0");
    chk_seg_pixel: assert property (@(posedge CLK) disable iff (RST)
        !hold && !OPTS.grp_b_logic |=> SEG_LEVEL[8] == $past(pix8_ref))
        else $error("segment level disagrees with pixel");
    chk_quarter_seg_off: assert property (@(posedge CLK) disable iff (RST)
        OPTS.duty == lcdd_pkg::DUTY_QUARTER |=> !SEG_LEVEL[46])
        else $error("last segment driven at quarter duty");
    chk_read_hit: assert property (@(posedge CLK) disable iff (RST)
        MEM_REQ.rd && disp_sel |=> MEM_HIT)
        else $error("display read gave no hit");
    chk_bank_write: assert property (@(posedge CLK) disable iff (RST)
        bank_wr |=> bank_q == $past(MEM_REQ.wdata))
        else $error("bank pointer write lost");

endmodule : lcdd_top

// ---- dv/lcdd_glass.sv ----
// behavioural lcd glass: which pixels a drive pattern lights
`timescale 1ns/10ps
module lcdd_glass (
    // drive from the segment driver
    input wire logic [3:0] com_level,
    input wire logic [3:0] com_active,
    input wire logic [46:0] seg_level,
    // pixel state, one row per common
    output logic [3:0][46:0] lit
);
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            // an idle common sits at mid level, so nothing on it can light
            lit[k] = com_active[k] ? (seg_level ^ {47{com_level[k]}}) : '0;
        end
    end
endmodule : lcdd_glass

// ---- dv/lcd_display_memory_segment_driver_tb.sv ----
// self-checking bench for the lcd display memory segment driver
`timescale 1ns/10ps
module lcd_display_memory_segment_driver_tb;
    logic clk, rst, halt, hit;
    lcdd_pkg::lcdd_mem_req_t req;
    lcdd_pkg::lcdd_opt_t opts;
    logic [7:0] rdata;
    logic [3:0] com_level, com_active;
    logic [46:0] seg_level;
    logic [3:0][46:0] lit;
    int mismatches, checked;

    lcdd_top dut (.CLK(clk), .RST(rst), .MEM_REQ(req), .MEM_RDATA(rdata), .MEM_HIT(hit), .OPTS(opts),
        .HALT(halt), .COM_LEVEL(com_level), .COM_ACTIVE(com_active), .SEG_LEVEL(seg_level));
    lcdd_glass glass (.com_level(com_level), .com_active(com_active), .seg_level(seg_level), .lit(lit));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // --------------------------------------------------------------
    // compare, access and closing tasks
    // --------------------------------------------------------------
    task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check8

    task automatic check1(input logic got, input logic exp, input string what);
        check8({7'h00, got}, {7'h00, exp}, what);
    endtask : check1

    // one idle edge first, so a request is never raised in the step that lowers the last one
    task automatic mem(input logic wr, input logic ind, input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk);
        #1;
        req = '{wr: wr, rd: ~wr, indirect: ind, addr: addr, wdata: data};
        @(posedge clk);
        #1;
        req = '0;
    endtask : mem

    task automatic rd_chk(input logic ind, input logic [7:0] addr, input logic [7:0] exp);
        mem(1'b0, ind, addr, 8'h00);
        check1(hit, 1'b1, "read hit");
        check8(rdata, exp, "read data");
    endtask : rd_chk

    task automatic complete_run;
        $display("mismatches=%0d checked=%0d", mismatches, checked);
        if (mismatches == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : complete_run

    // bit 0 differs from the upper bits so a wrong bit choice shows
    function automatic logic [7:0] pat(input int n);
        return (n % 3 == 0) ? 8'h01 : 8'h0E;
    endfunction : pat

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    initial begin
        logic [7:0] b;
        rst = 1'b1;
        halt = 1'b0;
        req = '0;
        opts = '{duty: lcdd_pkg::DUTY_THIRD, grp_a_logic: 1'b0, grp_b_logic: 1'b0, bit_logic: 8'h00};
        repeat (20) @(posedge clk);
        #1;
        check8({4'h0, com_active}, 8'h00, "commons in reset");
        rst = 1'b0;
        rd_chk(1'b0, lcdd_pkg::BANK_SELECT_POINTER_ADDR, lcdd_pkg::BANK_SELECT_POINTER_RST);
        mem(1'b1, 1'b0, lcdd_pkg::BANK_SELECT_POINTER_ADDR, lcdd_pkg::DISP_BANK);
        rd_chk(1'b0, lcdd_pkg::BANK_SELECT_POINTER_ADDR, 8'h01);
        for (int n = 0; n < 47; n++) mem(1'b1, 1'b1, 8'h40 + 8'(n), pat(n));
        rd_chk(1'b1, 8'h6E, pat(46));
        rd_chk(1'b1, 8'h40, pat(0));
        mem(1'b1, 1'b0, 8'h41, 8'hFF);
        rd_chk(1'b1, 8'h41, pat(1));
        foreach (b[i]) if (i < 3) begin
            mem(1'b1, 1'b0, lcdd_pkg::BANK_SELECT_POINTER_ADDR, (i == 0) ? 8'h00 : 8'(i + 1));
            mem(1'b1, 1'b1, 8'h42, 8'hAA);
        end
        mem(1'b1, 1'b0, lcdd_pkg::BANK_SELECT_POINTER_ADDR, 8'h01);
        rd_chk(1'b1, 8'h42, pat(2));
        repeat (3) @(posedge clk);
        #1;
        for (int n = 0; n < 47; n++) check1(lit[0][n], pat(n) == 8'h01, "pixel on first common");
        check1(|{lit[3], lit[2], lit[1]}, 1'b0, "other commons idle");
        opts = '{duty: lcdd_pkg::DUTY_THIRD, grp_a_logic: 1'b1, grp_b_logic: 1'b1, bit_logic: 8'h5A};
        repeat (3) @(posedge clk);
        #1;
        for (int n = 0; n < 24; n++) check1(seg_level[n], pat(n) == 8'h01, "logic output");
        halt = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        check8({4'h0, com_active}, 8'h00, "commons in halt");
        for (int n = 0; n < 24; n++) begin
            check1(seg_level[n], (n < 16 || opts.bit_logic[n % 8]) && pat(n) == 8'h01, "logic output in halt");
        end
        check1(|seg_level[46:24], 1'b0, "scan segments in halt");
        halt = 1'b0;
        repeat (5) @(posedge clk);
        #1;
        check1(com_active[0], 1'b1, "scan resumed");
        mem(1'b1, 1'b1, 8'h6E, 8'h01);
        opts.duty = lcdd_pkg::DUTY_QUARTER;
        repeat (3) @(posedge clk);
        #1;
        check1(seg_level[46], 1'b0, "unused segment at quarter duty");
        opts.duty = lcdd_pkg::DUTY_HALF;
        repeat (3) @(posedge clk);
        #1;
        check1(lit[0][46], 1'b1, "last pixel at half duty");
        check1(|{lit[3], lit[2], com_active[3:2]}, 1'b0, "third common idle at half duty");
        rst = 1'b1;
        #1;
        check1(|{com_active, seg_level}, 1'b0, "drive in second reset");
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        rd_chk(1'b0, lcdd_pkg::BANK_SELECT_POINTER_ADDR, lcdd_pkg::BANK_SELECT_POINTER_RST);
        complete_run();
    end

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        $display("CHECK FAILED at %0t: run did not finish", $time);
        complete_run();
    end
endmodule : lcd_display_memory_segment_driver_tb
